/* File: hdl/mac_addr_hash_mgmt_defines.vh */
/*
 * constants for the station address, group hash and phy management register bank.
 * assumes the includer uses word indices times four as apb byte addresses.
 */
`ifndef MAC_ADDR_HASH_MGMT_DEFINES_VH
`define MAC_ADDR_HASH_MGMT_DEFINES_VH

// ----------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------
`define IDX_MAC_CTRL      4'h1
`define IDX_ADDR_HIGH     4'h2
`define IDX_ADDR_LOW      4'h3
`define IDX_HASH_HIGH     4'h4
`define IDX_HASH_LOW      4'h5
`define IDX_MGMT_ACC      4'h6
`define IDX_MGMT_DATA     4'h7

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_ADDR_LOW      32'h0fffffff
`define RST_ADDR_HIGH     16'hffff
`define RST_HASH          32'h00000000

// ----------------------------------------
// field positions, management clock divider, frame bit positions and sizes
// ----------------------------------------
`define BIT_PASS_ALL      19
`define BIT_BUSY          0
`define BIT_WNR           1
`define MGMT_CLK_DIV      8'h13
`define MGMT_FRAME_BITS   7'h40
`define MGMT_TA_BIT       7'h2e
`define MGMT_RD_FIRST     7'h30
`define HASH_BITS         64

`endif

/* File: hdl/mac_addr_hash_mgmt_regs.v */
/*
 * station address, group hash filter and phy management register bank.
 * assumes an apb master on pclk, a config-memory controller presenting load bytes,
 * and a receive path presenting the hash index of each group frame.
 */
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "mac_addr_hash_mgmt_defines.vh"

module mac_addr_hash_mgmt_regs (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        clk_en,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        cfg_present,
	input  wire        cfg_byte_valid,
	input  wire [2:0]  cfg_byte_index,
	input  wire [7:0]  cfg_byte_data,
	input  wire        cfg_done,
	output reg         init_done,
	input  wire        grp_valid,
	input  wire [5:0]  grp_hash_index,
	output reg         grp_accept,
	output reg  [47:0] station_address_wire,
	output reg         mdc,
	output reg         mdio_out,
	output reg         mdio_oe_n,
	input  wire        mdio_in
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg [31:0] station_address_low_q;
	reg [15:0] station_address_high_q;
	reg [31:0] group_hash_table_high_q;
	reg [31:0] group_hash_table_low_q;
	reg        pass_all_group_frames_q;
	reg [4:0]  phy_addr_q;
	reg [4:0]  phy_register_index_q;
	reg        phy_write_not_read_q;
	reg        phy_access_busy_q;
	reg [15:0] mgmt_data_q;
	reg        mdio_s1_q;
	reg        mdio_s2_q;
	reg [7:0]  div_q;
	reg [6:0]  bit_q;
	reg [63:0] shift_q;
	reg [15:0] rd_shift_q;

	wire [3:0] idx = paddr[5:2];
	wire       mapped = (paddr[11:6] == 6'h00) && (idx >= `IDX_MAC_CTRL) && (idx <= `IDX_MGMT_DATA);
	wire       acc = psel && penable && !pready;
	wire       wr = acc && pwrite && mapped;
	wire       rise = (div_q == `MGMT_CLK_DIV) && !mdc;
	wire       fall = (div_q == `MGMT_CLK_DIV) && mdc;

	// ----------------------------------------
	// apb slave: one wait state, unmapped answers with pslverr
	// ----------------------------------------
	reg [31:0] rd_d;
	always @* begin
		case (idx)
		`IDX_MAC_CTRL:  rd_d = {12'h000, pass_all_group_frames_q, 19'h00000};
		`IDX_ADDR_HIGH: rd_d = {16'h0000, station_address_high_q};
		`IDX_ADDR_LOW:  rd_d = station_address_low_q;
		`IDX_HASH_HIGH: rd_d = group_hash_table_high_q;
		`IDX_HASH_LOW:  rd_d = group_hash_table_low_q;
		`IDX_MGMT_ACC:  rd_d = {16'h0000, phy_addr_q, phy_register_index_q, 4'h0,
		                        phy_write_not_read_q, phy_access_busy_q};
		`IDX_MGMT_DATA: rd_d = {16'h0000, mgmt_data_q};
		default:        rd_d = 32'h00000000;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready  <= acc;
			pslverr <= acc && !mapped;
			prdata  <= (acc && !pwrite && mapped) ? rd_d : 32'h00000000;
		end
	end

	// ----------------------------------------
	// station address: power-on load then host writes
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			station_address_low_q  <= `RST_ADDR_LOW;
			station_address_high_q <= `RST_ADDR_HIGH;
			init_done              <= 1'b0;
		end else if (clk_en) begin
			if (!init_done) begin
				if (cfg_present && cfg_byte_valid) begin
					case (cfg_byte_index)
					3'h1: station_address_low_q[7:0]    <= cfg_byte_data;
					3'h2: station_address_low_q[15:8]   <= cfg_byte_data;
					3'h3: station_address_low_q[23:16]  <= cfg_byte_data;
					3'h4: station_address_low_q[31:24]  <= cfg_byte_data;
					3'h5: station_address_high_q[7:0]   <= cfg_byte_data;
					3'h6: station_address_high_q[15:8]  <= cfg_byte_data;
					default: ;
					endcase
				end
				if (cfg_done || !cfg_present)
					init_done <= 1'b1;
			end else if (wr && idx == `IDX_ADDR_LOW) begin
				station_address_low_q <= pwdata;
			end else if (wr && idx == `IDX_ADDR_HIGH) begin
				station_address_high_q <= pwdata[15:0];
			end
		end
	end

	// byte 0 of the wire vector is the first on the medium
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			station_address_wire <= 48'h000000000000;
		else if (clk_en)
			station_address_wire <= {station_address_high_q, station_address_low_q};
	end

	// ----------------------------------------
	// group hash filter
	// ----------------------------------------
	// one decoded hit per table bit; the high register holds table bits 63:32
	wire [63:0] hash_table = {group_hash_table_high_q, group_hash_table_low_q};
	wire [63:0] hash_hit;
	genvar      g;
	generate
		for (g = 0; g < `HASH_BITS; g = g + 1) begin : g_hash_bit
			localparam [5:0] SEL = g;
			assign hash_hit[g] = (grp_hash_index == SEL) && hash_table[g];
		end
	endgenerate

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			group_hash_table_high_q <= `RST_HASH;
			group_hash_table_low_q  <= `RST_HASH;
			pass_all_group_frames_q <= 1'b0;
			grp_accept              <= 1'b0;
		end else if (clk_en) begin
			if (wr && idx == `IDX_HASH_HIGH)
				group_hash_table_high_q <= pwdata;
			if (wr && idx == `IDX_HASH_LOW)
				group_hash_table_low_q <= pwdata;
			if (wr && idx == `IDX_MAC_CTRL)
				pass_all_group_frames_q <= pwdata[`BIT_PASS_ALL];
			grp_accept <= grp_valid && (pass_all_group_frames_q || (|hash_hit));
		end
	end

	// ----------------------------------------
	// management access engine
	// ----------------------------------------
	// writes to access or data while busy are dropped, so a careless host cannot corrupt a frame
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mdio_s1_q <= 1'b0;
			mdio_s2_q <= 1'b0;
		end else if (clk_en) begin
			mdio_s1_q <= mdio_in;
			mdio_s2_q <= mdio_s1_q;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phy_addr_q           <= 5'h00;
			phy_register_index_q <= 5'h00;
			phy_write_not_read_q <= 1'b0;
			phy_access_busy_q    <= 1'b0;
			mgmt_data_q          <= 16'h0000;
			div_q                <= 8'h00;
			bit_q                <= 7'h00;
			shift_q              <= 64'h0000000000000000;
			rd_shift_q           <= 16'h0000;
			mdc                  <= 1'b0;
			mdio_out             <= 1'b1;
			mdio_oe_n            <= 1'b1;
		end else if (clk_en) begin
			if (!phy_access_busy_q) begin
				mdc       <= 1'b0;
				div_q     <= 8'h00;
				mdio_oe_n <= 1'b1;
				if (wr && idx == `IDX_MGMT_DATA)
					mgmt_data_q <= pwdata[15:0];
				if (wr && idx == `IDX_MGMT_ACC) begin
					phy_addr_q           <= pwdata[15:11];
					phy_register_index_q <= pwdata[10:6];
					phy_write_not_read_q <= pwdata[`BIT_WNR];
					phy_access_busy_q    <= pwdata[`BIT_BUSY];
					bit_q                <= 7'h00;
					// preamble, start, opcode, phy, reg, turnaround, data
					shift_q <= {32'hffffffff, 2'b01, pwdata[`BIT_WNR] ? 2'b01 : 2'b10,
					            pwdata[15:11], pwdata[10:6], 2'b10, mgmt_data_q};
				end
			end else begin
				div_q <= (div_q == `MGMT_CLK_DIV) ? 8'h00 : div_q + 8'h01;
				if (fall) begin
					mdc       <= 1'b0;
					mdio_out  <= shift_q[63];
					shift_q   <= {shift_q[62:0], 1'b1};
					// on reads the phy owns the line from the turnaround on
					mdio_oe_n <= !(phy_write_not_read_q || bit_q < `MGMT_TA_BIT);
					bit_q     <= bit_q + 7'h01;
					if (bit_q == `MGMT_FRAME_BITS) begin
						mdio_oe_n         <= 1'b1;
						phy_access_busy_q <= 1'b0;
						if (!phy_write_not_read_q)
							mgmt_data_q <= rd_shift_q;
					end
				end
				if (rise) begin
					mdc <= 1'b1;
					if (bit_q > `MGMT_RD_FIRST)
						rd_shift_q <= {rd_shift_q[14:0], mdio_s2_q};
				end
			end
		end
	end

endmodule // mac_addr_hash_mgmt_regs
`default_nettype wire

/* File: test/mac_addr_hash_mgmt_regs_asserts.sv */
/* port checks for the address, hash and phy management bank.
 assumes clk_en is held high by the bench. */
`timescale 1ns/10ps
`default_nettype none
module mac_addr_hash_mgmt_regs_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic cfg_done,
	input wire logic init_done,
	input wire logic grp_valid,
	input wire logic grp_accept,
	input wire logic mdc,
	input wire logic mdio_out
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence apb_wait;
		psel && penable && !pready;
	endsequence
	a_ready_one_wait: assert property (apb_wait |=> pready) else $error("pready late");
	a_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("pready without access");
	a_ready_pulse: assert property (apb_wait ##1 pready |=> !pready) else $error("pready too long");
	a_accept_cause: assert property (grp_accept |-> $past(grp_valid)) else $error("accept without frame");
	a_accept_one: assert property (grp_accept && !grp_valid |=> !grp_accept) else $error("accept too long");
	a_init_on_done: assert property (cfg_done |-> ##[1:2] init_done) else $error("load not finished");
	a_init_stays: assert property (init_done |=> init_done) else $error("init lost");
	a_mdio_at_rise: assert property ($rose(mdc) |-> $stable(mdio_out)) else $error("mdio moved at mdc rise");
	a_mdc_half: assert property ($changed(mdc) |=> $stable(mdc) [*8]) else $error("mdc too fast");
endmodule // mac_addr_hash_mgmt_regs_asserts
`default_nettype wire

/* File: test/phy_mgmt_model.sv */
/* behavioural phy on the management wire.
 assumes a pull-up, so a released line reads one. */
`timescale 1ns/10ps
`default_nettype none
module phy_mgmt_model (
	input wire logic        mdc,
	input wire logic        mdio_out,
	input wire logic        mdio_oe_n,
	input wire logic [15:0] rd_data,
	output var logic        mdio_drv,
	output var logic [12:0] hdr,
	output var logic [15:0] wr_data
);
	int   ones = 0;
	int   n = 0;
	logic b;
	initial mdio_drv = 1'b1;
	always @(posedge mdc) begin
		b = mdio_oe_n ? mdio_drv : mdio_out;
		if (n == 0) begin
			if (b == 1'b0 && ones >= 32) n = 1;
			ones = b ? ones + 1 : 0;
		end else begin
			n = n + 1;
			if (n <= 14) hdr = {hdr[11:0], b};
			else if (n >= 17) wr_data = {wr_data[14:0], b};
			// a read answer changes just after the rise so it is settled at the next one
			if (hdr[11:10] == 2'b10 && n >= 15 && n < 32) mdio_drv = (n == 15) ? 1'b0 : rd_data[31 - n];
			else mdio_drv = 1'b1;
			if (n == 32) n = 0;
		end
	end
endmodule // phy_mgmt_model
`default_nettype wire

/* File: test/tb_mac_addr_hash_mgmt_regs.sv */
/* bench for the address, hash and phy management bank.
 assumes the phy model and one 100 MHz clock. */
`timescale 1ns/10ps
`default_nettype none
module tb_mac_addr_hash_mgmt_regs;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, cfg_byte_valid, cfg_done, init_done, er;
	logic        grp_valid, grp_accept, mdc, mdio_out, mdio_oe_n, mdio_drv, cfg_present;
	logic [2:0]  cfg_byte_index;
	logic [5:0]  grp_hash_index;
	logic [7:0]  cfg_byte_data;
	logic [11:0] paddr;
	logic [12:0] hdr;
	logic [15:0] rdat, wr_data;
	logic [31:0] pwdata, prdata, rd, w;
	logic [47:0] station_address_wire, mac;
	logic [63:0] tbl;
	integer      seed, miscompares, comparisons, i, j, k;
	mac_addr_hash_mgmt_regs DUT (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cfg_present(cfg_present), .cfg_byte_valid(cfg_byte_valid), .cfg_byte_index(cfg_byte_index),
		.cfg_byte_data(cfg_byte_data), .cfg_done(cfg_done), .init_done(init_done), .grp_valid(grp_valid),
		.grp_hash_index(grp_hash_index), .grp_accept(grp_accept), .station_address_wire(station_address_wire),
		.mdc(mdc), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .mdio_in(mdio_oe_n ? mdio_drv : mdio_out));
	phy_mgmt_model phy (.mdc(mdc), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .rd_data(rdat),
		.mdio_drv(mdio_drv), .hdr(hdr), .wr_data(wr_data));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task test_done;
		$display("miscompares %0d comparisons %0d", miscompares, comparisons);
		if (miscompares == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task chk(input logic [47:0] e, g, input string nm);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task apb(input logic wr, input logic [3:0] ix, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {6'h00, ix, 2'h0};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			miscompares++;
			test_done;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	initial begin
		{seed, miscompares, comparisons} = {32'd16151, 64'd0};
		{presetn, psel, penable, pwrite, paddr, pwdata, cfg_byte_valid, cfg_done, grp_valid} = 0;
		{cfg_byte_index, cfg_byte_data, grp_hash_index, rdat} = 0;
		cfg_present = 1'b1;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 3, 0);
		chk(32'h0fffffff, rd, "addr_low_reset");
		for (i = 4; i < 8; i++) begin
			apb(0, i[3:0], 0);
			chk(0, rd, "reset_value");
		end
		apb(1, 3, 32'h0000aa55);
		for (i = 1; i < 7; i++) begin
			@(posedge pclk);
			mac[8*i-8 +: 8] = $random(seed);
			cfg_byte_valid <= 1'b1;
			cfg_byte_index <= i[2:0];
			cfg_byte_data <= mac[8*i-8 +: 8];
		end
		@(posedge pclk);
		cfg_byte_valid <= 1'b0;
		chk(0, init_done, "init_before_done");
		cfg_done <= 1'b1;
		@(posedge pclk);
		cfg_done <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(1, init_done, "init_done");
		chk(mac, station_address_wire, "wire_order");
		apb(0, 3, 0);
		chk(mac[31:0], rd, "addr_low_load");
		apb(0, 2, 0);
		chk(mac[47:32], rd, "addr_high_load");
		w = $random(seed);
		apb(1, 3, w);
		apb(0, 3, 0);
		chk(w, rd, "addr_low_rw");
		chk(w, station_address_wire[31:0], "wire_low");
		apb(0, 0, 0);
		chk(33'h100000000, {er, rd}, "unmapped");
		tbl = {$random(seed), $random(seed)};
		apb(1, 4, tbl[63:32]);
		apb(1, 5, tbl[31:0]);
		for (j = 0; j < 2; j++) begin
			apb(1, 1, j << 19);
			for (i = 0; i < 24; i++) begin
				@(posedge pclk);
				grp_valid <= 1'b1;
				grp_hash_index <= (i < 2) ? 6'(i * 63) : 6'($random(seed));
				@(posedge pclk);
				grp_valid <= 1'b0;
				#1 chk(j[0] | tbl[grp_hash_index], grp_accept, "group_accept");
			end
		end
		for (j = 0; j < 2; j++) begin
			w = $random(seed);
			rdat = $random(seed);
			i = $random(seed);
			apb(1, 7, w);
			apb(1, 6, {16'h0000, 5'b00001, i[4:0], 4'h0, j[0], 1'b1});
			apb(0, 6, 0);
			chk(1, rd[0], "busy_set");
			for (k = 0; rd[0] !== 1'b0 && k < 2000; k++) apb(0, 6, 0);
			if (k >= 2000) begin
				miscompares++;
				test_done;
			end
			chk({1'b1, j ? 2'b01 : 2'b10, 5'b00001, i[4:0]}, hdr, "frame_header");
			apb(0, 7, 0);
			chk(j ? w[15:0] : rdat, j ? wr_data : rd[15:0], "phy_data");
		end
		@(posedge pclk);
		cfg_present <= 1'b0;
		presetn <= 1'b0;
		@(posedge pclk);
		chk(0, init_done, "init_in_reset");
		presetn <= 1'b1;
		@(posedge pclk);
		cfg_byte_valid <= 1'b1;
		cfg_byte_index <= 3'h1;
		cfg_byte_data <= 8'h5a;
		@(posedge pclk);
		cfg_byte_valid <= 1'b0;
		#1 chk(1, init_done, "init_no_cfg");
		apb(0, 3, 0);
		chk(32'h0fffffff, rd, "addr_low_no_load");
		test_done;
	end
endmodule // tb_mac_addr_hash_mgmt_regs
bind mac_addr_hash_mgmt_regs mac_addr_hash_mgmt_regs_asserts chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .cfg_done(cfg_done), .init_done(init_done), .grp_valid(grp_valid),
	.grp_accept(grp_accept), .mdc(mdc), .mdio_out(mdio_out));
`default_nettype wire
